// *** rtl/ssxc_top.sv ***
// Extended serial port: Wishbone registers, clock divider, transmitter, receiver.
//
// Design decisions made here: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ssxc_top (
	input wire logic CLK, // 100 MHz system clock.
	input wire logic RST_N, // Asynchronous reset, active low.
	input wire logic WB_CYC_I, // Wishbone cycle.
	input wire logic WB_STB_I, // Wishbone strobe.
	input wire logic WB_WE_I, // Wishbone write enable.
	input wire logic [7:0] WB_ADR_I, // Wishbone byte address.
	input wire logic [3:0] WB_SEL_I, // Wishbone byte selects.
	input wire logic [31:0] WB_DAT_I, // Wishbone write data.
	output logic [31:0] WB_DAT_O, // Wishbone read data.
	output logic WB_ACK_O, // Wishbone acknowledge.
	input wire logic RX_BIT_CLOCK, // Receive bit clock pin.
	input wire logic RX_FRAME_SYNC, // Receive frame sync pin.
	input wire logic RX_DATA, // Receive data pin.
	input wire logic TX_BIT_CLOCK_IN, // Transmit bit clock pin, input side.
	output logic TX_BIT_CLOCK_OUT, // Transmit bit clock, output side.
	output logic TX_BIT_CLOCK_OE, // High while the bit clock is driven.
	input wire logic TX_FRAME_SYNC_IN, // Transmit frame sync pin, input side.
	output logic TX_FRAME_SYNC_OUT, // Transmit frame sync, output side.
	output logic TX_FRAME_SYNC_OE, // High while the frame sync is driven.
	output logic TX_DATA_OUT, // Transmit data pin level.
	output logic TX_DATA_OE // High while the data pin is driven.
);
	logic rst_meta, rst_n;
	logic [15:0] ext_ctrl, basic_ctrl, tx_data_reg;
	logic [15:0] next_ext_ctrl, next_basic_ctrl, next_tx_data_reg;
	logic tx_full, next_tx_full, overrun, next_overrun;
	logic ack, next_ack;
	logic [31:0] rdata, next_rdata;
	logic bus_req, bus_wr, bus_rd, rx_pop;
	logic word_skip, frame_ignore, clk_pol, sync_pol, int_clk;
	logic tx_cont, rx_cont, tx_int_sync, tx_en, rx_en;
	logic [1:0] fmt;
	logic [4:0] len, div;

	// Reset release through two flops; assertion stays asynchronous.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// Field decode of the two control registers.
	assign word_skip = ext_ctrl[ssxc_pkg::EXT_WORD_SKIP];
	assign frame_ignore = ext_ctrl[ssxc_pkg::EXT_FRAME_IGNORE];
	assign clk_pol = ext_ctrl[ssxc_pkg::EXT_CLK_POL];
	assign sync_pol = ext_ctrl[ssxc_pkg::EXT_SYNC_POL];
	assign div = ext_ctrl[ssxc_pkg::EXT_DIV_HI:0];
	assign fmt = {basic_ctrl[ssxc_pkg::BAS_FORMAT_SELECT],
		ext_ctrl[ssxc_pkg::EXT_FORMAT_EXTEND]};
	assign len = ssxc_pkg::word_len(fmt);
	assign int_clk = basic_ctrl[ssxc_pkg::BAS_INTERNAL_CLOCK];
	assign tx_cont = basic_ctrl[ssxc_pkg::BAS_TX_CONT];
	assign rx_cont = basic_ctrl[ssxc_pkg::BAS_RX_CONT];
	assign tx_int_sync = basic_ctrl[ssxc_pkg::BAS_TX_INT_SYNC];
	assign tx_en = basic_ctrl[ssxc_pkg::BAS_TX_EN];
	assign rx_en = basic_ctrl[ssxc_pkg::BAS_RX_EN];

	// Pin synchronisers; only the second stage and later are read.
	logic [4:0] pin_meta, pin_sync, pin_prev;
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta <= '0;
			pin_sync <= '0;
			pin_prev <= '0;
		end else begin
			pin_meta <= {TX_FRAME_SYNC_IN, TX_BIT_CLOCK_IN, RX_DATA,
				RX_FRAME_SYNC, RX_BIT_CLOCK};
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// Bit clock divider; the phase lengths come from the divider parity and, for even dividers, clk_pol.
	logic [4:0] div_cnt, next_div_cnt, hi_len;
	logic gen_level, next_gen_level, gen_rise, gen_fall;
	always_comb begin
		if (div[0]) begin
			// One extra bit keeps the top divider value from wrapping to zero.
			hi_len = 5'(({1'b0, div} + 6'h01) >> 1);
		end else begin
			hi_len = clk_pol ? 5'(div >> 1) : 5'((div >> 1) + 5'h01);
		end
		next_div_cnt = (div_cnt >= div) ? '0 : div_cnt + 5'h01;
		if (div == '0) begin
			next_gen_level = !gen_level;
		end else begin
			next_gen_level = (next_div_cnt < hi_len);
		end
	end
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt <= '0;
			gen_level <= 1'b0;
		end else begin
			div_cnt <= next_div_cnt;
			gen_level <= next_gen_level;
		end
	end
	assign gen_rise = next_gen_level && !gen_level;
	assign gen_fall = !next_gen_level && gen_level;

	// Edge selection per polarity; receive never looks at word-skip.
	logic ext_tx_rise, ext_tx_fall, tx_launch, rx_sample;
	logic rx_rise, rx_fall, tx_sync_act, rx_sync_act;
	assign ext_tx_rise = pin_sync[3] && !pin_prev[3];
	assign ext_tx_fall = !pin_sync[3] && pin_prev[3];
	assign rx_rise = pin_sync[0] && !pin_prev[0];
	assign rx_fall = !pin_sync[0] && pin_prev[0];
	always_comb begin
		if (clk_pol) begin
			tx_launch = int_clk ? gen_fall : ext_tx_fall;
			rx_sample = rx_rise;
		end else begin
			tx_launch = int_clk ? gen_rise : ext_tx_rise;
			rx_sample = rx_fall;
		end
	end
	assign tx_sync_act = pin_sync[4] ^ sync_pol;
	assign rx_sync_act = pin_sync[1] ^ sync_pol;

	// Transmitter state.
	logic tx_busy, next_tx_busy, tx_skip, next_tx_skip;
	logic tx_sync_prev, next_tx_sync_prev, fs_drive, next_fs_drive;
	logic [15:0] tx_shift, next_tx_shift;
	logic [4:0] tx_cnt, next_tx_cnt;
	logic tx_start, tx_load, tx_sync_edge, tx_ignore;
	assign tx_sync_edge = tx_int_sync ? fs_drive : (tx_sync_act && !tx_sync_prev);
	assign tx_ignore = tx_cont && !tx_int_sync && frame_ignore;
	assign tx_start = tx_en && tx_launch && tx_sync_edge
		&& (!tx_busy || !tx_ignore);
	always_comb begin
		next_tx_busy = tx_busy;
		next_tx_skip = tx_skip;
		next_tx_shift = tx_shift;
		next_tx_cnt = tx_cnt;
		next_tx_sync_prev = tx_sync_prev;
		next_fs_drive = fs_drive;
		tx_load = 1'b0;
		if (tx_launch) begin
			next_tx_sync_prev = tx_sync_act;
			next_fs_drive = tx_int_sync && tx_en && tx_full && !tx_busy
				&& !fs_drive;
			if (tx_start || (tx_busy && tx_cnt == '0 && tx_cont)) begin
				// Same copy path whatever word-skip says.
				tx_load = 1'b1;
				next_tx_busy = 1'b1;
				next_tx_shift = 16'(tx_data_reg << (ssxc_pkg::LEN16 - len));
				next_tx_skip = word_skip && tx_data_reg[ssxc_pkg::SIGN_BIT];
				next_tx_cnt = len - 5'h01;
			end else if (tx_busy && tx_cnt == '0) begin
				next_tx_busy = 1'b0;
				next_tx_skip = 1'b0;
			end else if (tx_busy) begin
				next_tx_shift = {tx_shift[14:0], 1'b0};
				next_tx_cnt = tx_cnt - 5'h01;
			end
		end
		if (!tx_en) begin
			next_tx_busy = 1'b0;
			next_fs_drive = 1'b0;
		end
	end
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			tx_busy <= 1'b0;
			tx_skip <= 1'b0;
			tx_shift <= '0;
			tx_cnt <= '0;
			tx_sync_prev <= 1'b0;
			fs_drive <= 1'b0;
		end else begin
			tx_busy <= next_tx_busy;
			tx_skip <= next_tx_skip;
			tx_shift <= next_tx_shift;
			tx_cnt <= next_tx_cnt;
			tx_sync_prev <= next_tx_sync_prev;
			fs_drive <= next_fs_drive;
		end
	end
	// A skipped word leaves the data pin floating for its whole period.
	assign TX_DATA_OUT = tx_shift[ssxc_pkg::SIGN_BIT];
	assign TX_DATA_OE = tx_busy && !tx_skip;
	assign TX_BIT_CLOCK_OUT = gen_level;
	assign TX_BIT_CLOCK_OE = int_clk;
	assign TX_FRAME_SYNC_OUT = fs_drive ^ sync_pol;
	assign TX_FRAME_SYNC_OE = tx_int_sync;

	// Receiver state; a finished word waits in a hold register if stalled.
	logic rx_busy, next_rx_busy, rx_sync_prev, next_rx_sync_prev;
	logic [15:0] rx_shift, next_rx_shift, rx_hold, next_rx_hold;
	logic [4:0] rx_cnt, next_rx_cnt;
	logic hold_valid, next_hold_valid, hold_ready, rx_done, rx_start, rx_lost;
	logic buf_valid;
	logic [15:0] buf_data;
	assign rx_start = rx_en && rx_sample && rx_sync_act && !rx_sync_prev
		&& (!rx_busy || !(rx_cont && frame_ignore));
	always_comb begin
		next_rx_busy = rx_busy;
		next_rx_shift = rx_shift;
		next_rx_cnt = rx_cnt;
		next_rx_sync_prev = rx_sync_prev;
		rx_done = 1'b0;
		if (rx_sample) begin
			next_rx_sync_prev = rx_sync_act;
			if (rx_start) begin
				next_rx_busy = 1'b1;
				next_rx_cnt = len;
			end else if (rx_busy) begin
				next_rx_shift = {rx_shift[14:0], pin_sync[2]};
				next_rx_cnt = rx_cnt - 5'h01;
				if (rx_cnt == 5'h01) begin
					rx_done = 1'b1;
					next_rx_busy = rx_cont;
					next_rx_cnt = len;
				end
			end
		end
		if (!rx_en) begin
			next_rx_busy = 1'b0;
		end
	end
	assign rx_lost = rx_done && hold_valid && !hold_ready;
	always_comb begin
		next_hold_valid = hold_valid && !hold_ready;
		next_rx_hold = rx_hold;
		if (rx_done && !rx_lost) begin
			next_hold_valid = 1'b1;
			next_rx_hold = ssxc_pkg::sign_ext(next_rx_shift, fmt);
		end
	end
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			rx_busy <= 1'b0;
			rx_shift <= '0;
			rx_cnt <= '0;
			rx_sync_prev <= 1'b0;
			hold_valid <= 1'b0;
			rx_hold <= '0;
		end else begin
			rx_busy <= next_rx_busy;
			rx_shift <= next_rx_shift;
			rx_cnt <= next_rx_cnt;
			rx_sync_prev <= next_rx_sync_prev;
			hold_valid <= next_hold_valid;
			rx_hold <= next_rx_hold;
		end
	end

	// Receive words queue here until software reads them.
	ssxc_fifo2 #(
		.WIDTH(ssxc_pkg::DATA_W),
		.DEPTH(2)
	) u_rx_buf (
		.clk(CLK),
		.rst_n(rst_n),
		.in_valid(hold_valid),
		.in_ready(hold_ready),
		.in_data(rx_hold),
		.out_valid(buf_valid),
		.out_ready(rx_pop),
		.out_data(buf_data)
	);

	// Byte-lane merge of a 16-bit register with the write data.
	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] sel);
		merge = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
	endfunction : merge

	// Wishbone slave: ack one cycle after the strobe, effects at the ack edge.
	assign bus_req = WB_CYC_I && WB_STB_I;
	assign bus_wr = bus_req && ack && WB_WE_I;
	assign bus_rd = bus_req && ack && !WB_WE_I;
	assign rx_pop = bus_rd && WB_ADR_I == ssxc_pkg::OFS_RX_DATA;
	always_comb begin
		next_ack = bus_req && !ack;
		next_rdata = rdata;
		next_ext_ctrl = ext_ctrl;
		next_basic_ctrl = basic_ctrl;
		next_tx_data_reg = tx_data_reg;
		next_tx_full = tx_full && !tx_load;
		next_overrun = overrun;
		if (bus_req && !ack) begin
			case (WB_ADR_I)
				ssxc_pkg::OFS_EXT_CTRL: next_rdata = {16'h0000, ext_ctrl};
				ssxc_pkg::OFS_BASIC_CTRL: next_rdata = {16'h0000, basic_ctrl};
				ssxc_pkg::OFS_TX_DATA: next_rdata = {16'h0000, tx_data_reg};
				ssxc_pkg::OFS_RX_DATA: next_rdata = {16'h0000, buf_data};
				ssxc_pkg::OFS_STATUS: next_rdata = {27'h0000000,
					rx_busy, tx_busy, overrun, buf_valid, !tx_full};
				default: next_rdata = 32'h00000000;
			endcase
		end
		if (bus_wr) begin
			case (WB_ADR_I)
				ssxc_pkg::OFS_EXT_CTRL: next_ext_ctrl =
					merge(ext_ctrl, WB_DAT_I, WB_SEL_I);
				ssxc_pkg::OFS_BASIC_CTRL: next_basic_ctrl =
					merge(basic_ctrl, WB_DAT_I, WB_SEL_I);
				ssxc_pkg::OFS_TX_DATA: begin
					// Short words are expected right-justified here.
					next_tx_data_reg = merge(tx_data_reg, WB_DAT_I, WB_SEL_I);
					next_tx_full = 1'b1;
				end
				ssxc_pkg::OFS_STATUS: begin
					if (WB_SEL_I[0] && WB_DAT_I[ssxc_pkg::ST_RX_OVERRUN]) begin
						next_overrun = 1'b0;
					end
				end
				default: next_overrun = overrun;
			endcase
		end
		// A lost word in the clearing cycle still sets the flag.
		if (rx_lost) begin
			next_overrun = 1'b1;
		end
	end
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			ack <= 1'b0;
			rdata <= '0;
			ext_ctrl <= ssxc_pkg::EXT_CTRL_RESET;
			basic_ctrl <= ssxc_pkg::BASIC_CTRL_RESET;
			tx_data_reg <= '0;
			tx_full <= 1'b0;
			overrun <= 1'b0;
		end else begin
			ack <= next_ack;
			rdata <= next_rdata;
			ext_ctrl <= next_ext_ctrl;
			basic_ctrl <= next_basic_ctrl;
			tx_data_reg <= next_tx_data_reg;
			tx_full <= next_tx_full;
			overrun <= next_overrun;
		end
	end
	assign WB_ACK_O = ack;
	assign WB_DAT_O = rdata;
endmodule : ssxc_top
`default_nettype wire

// *** include/ssxc_pkg.sv ***
// Constants, register map and helpers for the serial port extension control.
package ssxc_pkg;
	// Byte offsets on the Wishbone bus.
	localparam logic [7:0] OFS_EXT_CTRL = 8'h00;
	localparam logic [7:0] OFS_BASIC_CTRL = 8'h04;
	localparam logic [7:0] OFS_TX_DATA = 8'h08;
	localparam logic [7:0] OFS_RX_DATA = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	// Extension control layout.
	localparam logic [15:0] EXT_CTRL_RESET = 16'h0003;
	localparam int EXT_WORD_SKIP = 9;
	localparam int EXT_FRAME_IGNORE = 8;
	localparam int EXT_FORMAT_EXTEND = 7;
	localparam int EXT_CLK_POL = 6;
	localparam int EXT_SYNC_POL = 5;
	localparam int EXT_DIV_HI = 4;
	localparam int EXT_ENH_BITS = 10;
	// Basic control layout.
	localparam logic [15:0] BASIC_CTRL_RESET = 16'h0000;
	localparam int BAS_FORMAT_SELECT = 0;
	localparam int BAS_INTERNAL_CLOCK = 1;
	localparam int BAS_TX_CONT = 2;
	localparam int BAS_RX_CONT = 3;
	localparam int BAS_TX_INT_SYNC = 4;
	localparam int BAS_TX_EN = 5;
	localparam int BAS_RX_EN = 6;
	// Status layout.
	localparam int ST_TX_READY = 0;
	localparam int ST_RX_VALID = 1;
	localparam int ST_RX_OVERRUN = 2;
	localparam int ST_TX_BUSY = 3;
	localparam int ST_RX_BUSY = 4;
	localparam int DATA_W = 16;
	localparam int SIGN_BIT = 15;
	localparam logic [4:0] LEN16 = 5'h10;
	localparam logic [4:0] LEN10 = 5'h0a;
	localparam logic [4:0] LEN8 = 5'h08;
	localparam logic [4:0] LEN12 = 5'h0c;

	// Word length for the code {format_select, format_extend}.
	function automatic logic [4:0] word_len(input logic [1:0] code);
		case (code)
			2'h0: word_len = LEN16;
			2'h1: word_len = LEN10;
			2'h2: word_len = LEN8;
			default: word_len = LEN12;
		endcase
	endfunction : word_len

	// Right-justified word with its top bit copied upward.
	function automatic logic [15:0] sign_ext(input logic [15:0] v,
		input logic [1:0] code);
		case (code)
			2'h0: sign_ext = v;
			2'h1: sign_ext = {{6{v[9]}}, v[9:0]};
			2'h2: sign_ext = {{8{v[7]}}, v[7:0]};
			default: sign_ext = {{4{v[11]}}, v[11:0]};
		endcase
	endfunction : sign_ext
endpackage : ssxc_pkg

// *** rtl/ssxc_fifo2.sv ***
// Small valid/ready buffer between the receiver and the bus.
`timescale 1ns/1ps
`default_nettype none
module ssxc_fifo2 #(
	parameter int WIDTH = 16, // Word width.
	parameter int DEPTH = 2 // Number of entries.
) (
	input wire logic clk, // System clock.
	input wire logic rst_n, // Synchronised reset, active low.
	input wire logic in_valid, // Producer offers a word.
	output logic in_ready, // Buffer can take a word.
	input wire logic [WIDTH-1:0] in_data, // Offered word.
	output logic out_valid, // Buffer holds a word.
	input wire logic out_ready, // Consumer takes the head word.
	output logic [WIDTH-1:0] out_data // Head word.
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [AW:0] count, next_count;
	logic push, pop;

	// Handshakes; the full flag is exact, so the producer really stalls.
	assign in_ready = (count != FULL_CNT);
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Pointer and count updates with wrap at the depth.
	always_comb begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count = count;
		if (push) begin
			next_wr_ptr = (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
		end
		if (pop) begin
			next_rd_ptr = (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
		end
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end

	// Storage entries, each written only when addressed by a push.
	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++) begin : g_entry
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					mem[gi] <= '0;
				end else if (push && wr_ptr == AW'(gi)) begin
					mem[gi] <= in_data;
				end
			end
		end
	endgenerate
endmodule : ssxc_fifo2
`default_nettype wire

// *** verification/ssxc_properties.sv ***
// Checker of bus timing, register read-back and generated bit clock shape.
`timescale 1ns/1ps
`default_nettype none
module ssxc_properties (
	input wire logic CLK, // Clock.
	input wire logic RST_N, // Reset, active low.
	input wire logic WB_CYC_I, // Cycle.
	input wire logic WB_STB_I, // Strobe.
	input wire logic WB_WE_I, // Write.
	input wire logic [7:0] WB_ADR_I, // Address.
	input wire logic [3:0] WB_SEL_I, // Byte lanes.
	input wire logic [31:0] WB_DAT_I, // Write data.
	input wire logic [31:0] WB_DAT_O, // Read data.
	input wire logic WB_ACK_O, // Acknowledge.
	input wire logic TX_BIT_CLOCK_OUT, // Generated bit clock.
	input wire logic TX_BIT_CLOCK_OE, // Bit clock enable.
	input wire logic TX_FRAME_SYNC_OUT // Frame sync output.
);
	logic [15:0] ext, basic, next_ext, next_basic;
	logic [5:0] per, hi, next_per, next_hi, per_exp, hi_exp;
	logic [1:0] arm, next_arm;
	logic prev, rise, fall, wr_hit;
	logic [4:0] dv;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// Edges of the bit clock and the phase lengths its divider should give.
	assign wr_hit = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O;
	assign rise = TX_BIT_CLOCK_OUT && !prev;
	assign fall = !TX_BIT_CLOCK_OUT && prev;
	assign dv = ext[4:0];
	assign per_exp = (dv == 5'h00) ? 6'h02 : {1'b0, dv} + 6'h01;
	assign hi_exp = (dv == 5'h00) ? 6'h01 : (dv[0] || ext[6]) ?
		({1'b0, dv} + {5'h00, dv[0]}) >> 1 : ({1'b0, dv} >> 1) + 6'h01;
	// Shadows follow acknowledged writes; a new divider waits two rises.
	always_comb begin
		next_ext = ext;
		next_basic = basic;
		for (int b = 0; b < 16; b++) begin
			if (wr_hit && WB_SEL_I[b / 8] && WB_ADR_I == 8'h00)
				next_ext[b] = WB_DAT_I[b];
			if (wr_hit && WB_SEL_I[b / 8] && WB_ADR_I == 8'h04)
				next_basic[b] = WB_DAT_I[b];
		end
		next_per = rise ? 6'h01 : per + 6'h01;
		next_hi = rise ? 6'h01 : hi + {5'h00, TX_BIT_CLOCK_OUT};
		next_arm = (!TX_BIT_CLOCK_OE || next_ext != ext) ? 2'h0 :
			(rise && arm != 2'h2) ? arm + 2'h1 : arm;
	end
	// Register the shadows and the counters.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ext <= 16'h0003;
			basic <= 16'h0000;
			prev <= 1'b0;
			per <= 6'h00;
			hi <= 6'h00;
			arm <= 2'h0;
		end else begin
			ext <= next_ext;
			basic <= next_basic;
			prev <= TX_BIT_CLOCK_OUT;
			per <= next_per;
			hi <= next_hi;
			arm <= next_arm;
		end
	end
	AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("acknowledge lasted two cycles");
	AST_ACK_LAT: assert property (
		WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
		else $error("acknowledge not one cycle after request");
	AST_ACK_CAUSE: assert property (
		WB_ACK_O |-> $past(WB_CYC_I) && $past(WB_STB_I))
		else $error("acknowledge without request");
	AST_DAT_UPPER: assert property (
		WB_ACK_O |-> WB_DAT_O[31:16] == 16'h0000)
		else $error("upper read data not zero");
	AST_EXT_READ: assert property (
		WB_ACK_O && !WB_WE_I && WB_ADR_I == 8'h00 |-> WB_DAT_O[15:0] == ext)
		else $error("extension control read-back wrong");
	AST_CLK_OE: assert property (TX_BIT_CLOCK_OE == basic[1])
		else $error("bit clock enable differs from clock select");
	AST_SYNC_POL: assert property (
		!basic[5] && !$past(basic[5]) && $stable(ext[5])
		|-> TX_FRAME_SYNC_OUT == ext[5])
		else $error("idle frame sync level wrong");
	AST_DIV_PERIOD: assert property (rise && arm == 2'h2 |-> per == per_exp)
		else $error("bit clock period wrong");
	AST_DIV_HIGH: assert property (fall && arm == 2'h2 |-> hi == hi_exp)
		else $error("bit clock high phase wrong");
	cover property (rise && arm == 2'h2 && dv[0] == 1'b0);
	cover property (WB_ACK_O && WB_WE_I && WB_ADR_I == 8'h00);
	cover property (WB_ACK_O && !WB_WE_I && WB_ADR_I == 8'h0c);
endmodule : ssxc_properties
bind ssxc_top ssxc_properties u_props (.CLK(CLK), .RST_N(RST_N),
	.WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
	.WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
	.WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
	.TX_BIT_CLOCK_OUT(TX_BIT_CLOCK_OUT), .TX_BIT_CLOCK_OE(TX_BIT_CLOCK_OE),
	.TX_FRAME_SYNC_OUT(TX_FRAME_SYNC_OUT));
`default_nettype wire

// *** verification/ssxc_codec.sv ***
// Codec model sharing one bit clock and one frame sync for both directions.
`timescale 1ns/1ps
`default_nettype none
module ssxc_codec (
	input wire logic clk, // System clock pacing the pins.
	output logic bit_clk, // Bit clock, still between frames.
	output logic sync, // Frame sync.
	output logic dat, // Data towards the receiver.
	input wire logic tx_dat, // Data from the transmitter.
	input wire logic tx_oe // Transmitter drives its data pin.
);
	logic [15:0] cap; // Transmit bits, first bit highest.
	logic oe_lo; // Enable was low in some bit slot.
	logic oe_hi; // Enable was high in some bit slot.
	// Pins start idle so no edge reaches the design before a frame.
	initial begin
		bit_clk = 1'b0;
		sync = 1'b0;
		dat = 1'b0;
	end
	// A sync slot then len bits, 17 clocks a bit; the sync settles before
	// the clock moves, so a polarity change never looks like a frame.
	task automatic frame(input int len, input logic cp, input logic fp,
		input logic [15:0] w, input int extra);
		sync <= fp;
		repeat (16) @(posedge clk);
		bit_clk <= cp;
		repeat (16) @(posedge clk);
		cap = 16'h0000;
		oe_lo = 1'b0;
		oe_hi = 1'b0;
		for (int s = 0; s <= len; s++) begin
			bit_clk <= ~cp;
			sync <= ((s == 0) || (s == extra)) ^ fp;
			dat <= (s == 0) ? ~dat : w[len - s];
			repeat (8) @(posedge clk);
			@(negedge clk);
			if (s < len) begin
				cap = {cap[14:0], tx_dat};
				oe_lo = oe_lo | !tx_oe;
				oe_hi = oe_hi | tx_oe;
			end
			@(posedge clk);
			bit_clk <= cp;
			repeat (8) @(posedge clk);
		end
		sync <= fp;
		dat <= ~dat;
	endtask : frame
endmodule : ssxc_codec
`default_nettype wire

// *** verification/tb_top.sv ***
// Testbench: register accesses and codec frames with expected results.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic CLK = 1'b0;
	logic RST_N = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic wen = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic ack, bco, bcoe, fso, fsoe, tdo, tdoe, cbc, cfs, cdat;
	wire bc_pin;
	wire fs_pin;
	int err_total = 0;
	int checks = 0;
	int k;
	// Two-way pins carry whichever side enables its driver.
	assign bc_pin = bcoe ? bco : cbc;
	assign fs_pin = fsoe ? fso : cfs;
	always #5 CLK = ~CLK;
	ssxc_top dut (.CLK(CLK), .RST_N(RST_N), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(wen), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
		.WB_DAT_O(rdat), .WB_ACK_O(ack), .RX_BIT_CLOCK(cbc),
		.RX_FRAME_SYNC(cfs), .RX_DATA(cdat), .TX_BIT_CLOCK_IN(bc_pin),
		.TX_BIT_CLOCK_OUT(bco), .TX_BIT_CLOCK_OE(bcoe),
		.TX_FRAME_SYNC_IN(fs_pin), .TX_FRAME_SYNC_OUT(fso),
		.TX_FRAME_SYNC_OE(fsoe), .TX_DATA_OUT(tdo), .TX_DATA_OE(tdoe));
	ssxc_codec codec (.clk(CLK), .bit_clk(cbc), .sync(cfs), .dat(cdat),
		.tx_dat(tdo), .tx_oe(tdoe));
	task automatic tally_and_finish;
		if (err_total == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	// Classic cycle held until ack is sampled, then one idle cycle.
	task automatic bus(input logic we, input logic [7:0] a,
		input logic [15:0] d, input logic [3:0] s);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		wen <= we;
		adr <= a;
		sel <= s;
		wdat <= {16'h0000, d};
		while (ack !== 1'b1 && n < 40) begin
			@(posedge CLK);
			n++;
		end
		if (n >= 40) begin
			chk(16'h0000, 16'h0001);
			tally_and_finish;
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge CLK);
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [15:0] d,
		input logic [3:0] s);
		bus(1'b1, a, d, s);
	endtask : wr
	task automatic rdm(input logic [7:0] a, input logic [15:0] e,
		input logic [15:0] m);
		bus(1'b0, a, 16'h0000, 4'h3);
		chk(rdat[15:0] & m, e & m);
	endtask : rdm
	// One frame each way; short words are right-justified on both sides.
	task automatic xfer(input logic [1:0] code, input logic cp,
		input logic fp, input logic sk, input logic [15:0] tw,
		input logic [15:0] rw);
		int len;
		logic [15:0] m;
		len = (code == 2'h0) ? 16 : (code == 2'h1) ? 10 : 8;
		len = (code == 2'h3) ? 12 : len;
		m = 16'hffff >> (16 - len);
		wr(8'h04, {9'h000, 2'h3, 4'h0, code[1]}, 4'h3);
		wr(8'h00, {6'h00, sk, 1'b0, code[0], cp, fp, 5'h03}, 4'h3);
		wr(8'h08, tw & m, 4'h3);
		codec.frame(len, cp, fp, rw, 0);
		if (sk && tw[15]) begin
			chk({15'h0000, codec.oe_hi}, 16'h0000);
		end else begin
			chk(codec.cap & m, tw & m);
			chk({15'h0000, codec.oe_lo}, 16'h0000);
		end
		rdm(8'h0c, rw[len - 1] ? (rw | ~m) : (rw & m), 16'hffff);
	endtask : xfer
	// Main sequence; the reset is released on a clock edge.
	initial begin
		repeat (20) @(posedge CLK);
		RST_N <= 1'b1;
		repeat (3) @(posedge CLK);
		rdm(8'h00, 16'h0003, 16'hffff);
		rdm(8'h04, 16'h0000, 16'hffff);
		rdm(8'h10, 16'h0001, 16'h001f);
		wr(8'h00, 16'hffff, 4'h3);
		rdm(8'h00, 16'hffff, 16'hffff);
		wr(8'h00, 16'h0000, 4'h1);
		rdm(8'h00, 16'hff00, 16'hffff);
		wr(8'h14, 16'h1234, 4'h3);
		rdm(8'h14, 16'h0000, 16'hffff);
		wr(8'h04, 16'h0002, 4'h3);
		for (k = 0; k < 8; k++) begin
			wr(8'h00, {9'h000, k[1], 1'b0, 5'(k * 9)}, 4'h3);
			repeat (120) @(posedge CLK);
			chk({15'h0000, bcoe}, 16'h0001);
		end
		// Internal clock and sync: one word goes out, then the port idles.
		wr(8'h00, 16'h0003, 4'h3);
		wr(8'h04, 16'h0032, 4'h3);
		wr(8'h08, 16'h8001, 4'h3);
		repeat (20) @(posedge CLK);
		chk({14'h0000, fsoe, bcoe}, 16'h0003);
		rdm(8'h10, 16'h0009, 16'h0009);
		repeat (80) @(posedge CLK);
		rdm(8'h10, 16'h0001, 16'h0009);
		for (k = 0; k < 4; k++)
			xfer(k[1:0], k[0], k[1], 1'b0, 16'h5a3c, 16'hb6a5);
		xfer(2'h0, 1'b0, 1'b0, 1'b1, 16'h8123, 16'h4e71);
		xfer(2'h0, 1'b1, 1'b0, 1'b1, 16'h0123, 16'h9e71);
		// Four words with no reads: three are held, the fourth overruns.
		wr(8'h00, 16'h0003, 4'h3);
		wr(8'h04, 16'h0040, 4'h3);
		for (k = 0; k < 4; k++)
			codec.frame(16, 1'b0, 1'b0, 16'h1000 + 16'(k), 0);
		rdm(8'h10, 16'h0006, 16'h0006);
		for (k = 0; k < 3; k++)
			rdm(8'h0c, 16'h1000 + 16'(k), 16'hffff);
		rdm(8'h10, 16'h0000, 16'h0002);
		wr(8'h10, 16'h0004, 4'h3);
		rdm(8'h10, 16'h0000, 16'h0004);
		// A second sync mid-word in receive continuous mode.
		for (k = 0; k < 2; k++) begin
			wr(8'h04, 16'h0000, 4'h3);
			wr(8'h00, {7'h00, k[0], 8'h03}, 4'h3);
			wr(8'h04, 16'h0048, 4'h3);
			codec.frame(16, 1'b0, 1'b0, 16'hc3a5, 9);
			rdm(8'h10, {14'h0000, k[0], 1'b0}, 16'h0002);
			if (k == 1)
				rdm(8'h0c, 16'hc3a5, 16'hffff);
		end
		tally_and_finish;
	end
endmodule : tb_top
`default_nettype wire
